/* File: rtl/swb_link.v */
// Slave-side framing, timing recovery and Manchester transfer on the single-wire bus.
`timescale 1ns/1ns
`include "swb_map.vh"
module swb_link #(
  parameter [16:0] STBY_CYC     = `SWB_STBY_CYC,
  parameter [20:0] TWC_CYC      = `SWB_TWC_CYC,
  parameter [20:0] TWC_LONG_CYC = `SWB_TWC_LONG_CYC
) (
  input  wire       ref_clk,           // System clock, 125 MHz
  input  wire       resetn,            // Synchronous reset, active low
  input  wire       serial_io_line_i,  // Bus line level from the pin
  output reg        serial_io_line_o,  // Level driven onto the bus line
  output reg        serial_io_line_oe, // High while the slave drives the line
  output reg  [7:0] rx_data,           // Last received byte
  output reg        rx_valid,          // Pulse: rx_data updated
  output reg        mak_bit,           // Last master ack bit, 1 continues
  output reg        mak_valid,         // Pulse: mak_bit updated, ack_ok sampled
  input  wire       ack_ok,            // Answer slave ack (1) or NoACK (0)
  input  wire       tx_valid,          // Slave sends the next byte
  input  wire [7:0] tx_data,           // Byte the slave sends
  output reg        tx_take,           // Pulse: tx_data taken for sending
  output reg  [7:0] instr,             // Instruction register
  input  wire       wr_arm,            // A write is pending for a master NoACK
  input  wire       wr_long,           // Pending write is the long kind
  output wire       wr_busy,           // Self-timed write cycle running
  output reg        standby,           // Slave sits in standby
  output reg        sync_lost          // Pulse: missed or misplaced edge
);

  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_STBY = 3'h1;
  localparam [2:0] ST_HLOW = 3'h2;
  localparam [2:0] ST_HDR  = 3'h3;
  localparam [2:0] ST_RX   = 3'h4;
  localparam [2:0] ST_TX   = 3'h5;

  localparam [16:0] CNT_MAX = 17'h1FFFF;
  localparam [16:0] TE_MIN  = `SWB_TE_MIN_CYC;
  localparam [16:0] TE_MAX  = `SWB_TE_MAX_CYC;

  // First half of a Manchester bit: a one is low then high.
  function first_half;
    input b;
    begin
      first_half = ~b;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Line sampling
  // --------------------------------------------------------------------------
  wire line_lvl;
  wire line_rise;
  wire line_fall;
  wire line_edge;

  swb_sync u_sync (
    .clk    (ref_clk),
    .resetn (resetn),
    .din    (serial_io_line_i),
    .lvl    (line_lvl),
    .rise   (line_rise),
    .fall   (line_fall)
  );

  assign line_edge = line_rise | line_fall;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg  [2:0]  state_r;
  reg  [16:0] cnt_r;
  reg  [16:0] te_r;
  reg  [16:0] hi_cnt_r;
  reg         rose_r;
  reg  [3:0]  nedge_r;
  reg  [3:0]  nbit_r;
  reg  [7:0]  sh_r;
  reg         hdr_r;
  reg  [1:0]  byte_idx_r;
  reg  [7:0]  txsh_r;
  reg  [3:0]  txn_r;
  reg         txen_r;
  reg         txmid_r;
  reg         last_r;
  reg         wr_go_r;

  wire [16:0] half_w    = {1'b0, te_r[16:1]};
  wire [16:0] quarter_w = {2'b00, te_r[16:2]};
  wire [16:0] early_w   = te_r - quarter_w;
  wire [16:0] late_w    = te_r + quarter_w;
  wire [16:0] meas_w    = {2'b00, cnt_r[16:2]};
  // The level gate lets the falling edge that ends a standby pulse reach the frame engine.
  wire        stby_hit  = rose_r && line_lvl && (hi_cnt_r == STBY_CYC);

  // --------------------------------------------------------------------------
  // Standby pulse detector
  // --------------------------------------------------------------------------
  // A hit is held off until the line has risen once after reset, and counting
  // is cleared to zero while the slave drives, so its own high level never counts.
  always @(posedge ref_clk) begin
    if (!resetn) begin
      hi_cnt_r <= 17'h0;
      rose_r   <= 1'b0;
    end else begin
      if (line_rise) begin
        rose_r <= 1'b1;
      end
      if (!line_lvl || serial_io_line_oe) begin
        hi_cnt_r <= 17'h0;
      end else if (hi_cnt_r != STBY_CYC) begin
        hi_cnt_r <= hi_cnt_r + 17'h1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Frame engine
  // --------------------------------------------------------------------------
  // Edge windows: a middle edge is accepted from 0.75 to 1.25 bit periods
  // after the last reference. Jitter of 0.08 plus accumulated drift fits in
  // the quarter margin; earlier edges are bit-boundary edges and ignored.
  always @(posedge ref_clk) begin
    if (!resetn) begin
      state_r           <= ST_IDLE;
      cnt_r             <= 17'h0;
      te_r              <= 17'h0;
      nedge_r           <= 4'h0;
      nbit_r            <= 4'h0;
      sh_r              <= 8'h00;
      hdr_r             <= 1'b0;
      byte_idx_r        <= 2'h0;
      txsh_r            <= 8'h00;
      txn_r             <= 4'h0;
      txen_r            <= 1'b0;
      txmid_r           <= 1'b0;
      last_r            <= 1'b0;
      wr_go_r           <= 1'b0;
      serial_io_line_o  <= 1'b1;
      serial_io_line_oe <= 1'b0;
      rx_data           <= 8'h00;
      rx_valid          <= 1'b0;
      mak_bit           <= 1'b0;
      mak_valid         <= 1'b0;
      tx_take           <= 1'b0;
      instr             <= 8'h00;
      standby           <= 1'b0;
      sync_lost         <= 1'b0;
    end else begin
      rx_valid  <= 1'b0;
      mak_valid <= 1'b0;
      tx_take   <= 1'b0;
      wr_go_r   <= 1'b0;
      sync_lost <= 1'b0;
      if (cnt_r != CNT_MAX) begin
        cnt_r <= cnt_r + 17'h1;
      end
      if (stby_hit) begin
        state_r           <= ST_STBY;
        standby           <= 1'b1;
        serial_io_line_oe <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            serial_io_line_oe <= 1'b0;
          end
          ST_STBY: begin
            if (line_fall) begin
              state_r <= ST_HLOW;
              standby <= 1'b0;
            end
          end
          ST_HLOW: begin
            if (line_rise) begin
              state_r <= ST_HDR;
              nedge_r <= 4'h0;
              cnt_r   <= 17'h0;
            end
          end
          ST_HDR: begin
            if (line_edge) begin
              // Pattern 01010101 puts one middle edge per bit, falling first.
              if (line_rise == ~nedge_r[0]) begin
                state_r   <= ST_IDLE;
                sync_lost <= 1'b1;
              end else begin
                nedge_r <= nedge_r + 4'h1;
                if (nedge_r == 4'h0) begin
                  cnt_r <= 17'h0;
                end
                if (nedge_r == `SWB_HDR_MEAS_EDGE) begin
                  // Four bit periods span edges 0 to 4; the shift divides.
                  te_r <= meas_w;
                  if (meas_w < TE_MIN || meas_w > TE_MAX) begin
                    state_r   <= ST_IDLE;
                    sync_lost <= 1'b1;
                  end
                end
                if (nedge_r == `SWB_HDR_EDGES - 4'h1) begin
                  state_r    <= ST_RX;
                  nbit_r     <= `SWB_ACK_BIT;
                  hdr_r      <= 1'b1;
                  byte_idx_r <= 2'h0;
                  cnt_r      <= 17'h0;
                end
              end
            end else if (cnt_r == CNT_MAX) begin
              state_r   <= ST_IDLE;
              sync_lost <= 1'b1;
            end
          end
          ST_RX: begin
            if (line_edge && cnt_r >= early_w) begin
              cnt_r <= 17'h0;
              if (nbit_r != `SWB_ACK_BIT) begin
                // A rising middle edge carries a one.
                sh_r   <= {sh_r[6:0], line_rise};
                nbit_r <= nbit_r + 4'h1;
                if (nbit_r == `SWB_LAST_BIT) begin
                  rx_data  <= {sh_r[6:0], line_rise};
                  rx_valid <= 1'b1;
                  if (byte_idx_r != 2'h3) begin
                    byte_idx_r <= byte_idx_r + 2'h1;
                  end
                  if (byte_idx_r == `SWB_INSTR_BYTE) begin
                    instr <= {sh_r[6:0], line_rise};
                  end
                end
              end else begin
                // Master ack bit; its middle edge is the phase reference.
                mak_bit   <= line_rise;
                mak_valid <= 1'b1;
                if (!line_rise && wr_arm && !hdr_r) begin
                  wr_go_r <= 1'b1;
                end
                // The header is always answered with NoACK to avoid contention.
                txen_r  <= hdr_r ? 1'b0 : ack_ok;
                txsh_r  <= 8'h80;
                txn_r   <= 4'h1;
                txmid_r <= 1'b0;
                last_r  <= 1'b1;
                state_r <= ST_TX;
              end
            end else if (cnt_r > late_w) begin
              state_r   <= ST_IDLE;
              sync_lost <= 1'b1;
            end
          end
          ST_TX: begin
            if (!txmid_r && cnt_r == half_w) begin
              if (txn_r != 4'h0) begin
                serial_io_line_oe <= txen_r;
                serial_io_line_o  <= first_half(txsh_r[7]);
                txmid_r           <= 1'b1;
              end else if (!last_r) begin
                // Data byte sent; the master ack bit follows.
                serial_io_line_oe <= 1'b0;
                state_r           <= ST_RX;
                nbit_r            <= `SWB_ACK_BIT;
              end else begin
                serial_io_line_oe <= 1'b0;
                hdr_r             <= 1'b0;
                if (!mak_bit) begin
                  // NoACK plus slave ack is the clean end; any other goes idle.
                  state_r <= txen_r ? ST_STBY : ST_IDLE;
                  standby <= txen_r;
                end else if (tx_valid && !hdr_r) begin
                  // Next bit starts now, so its first half is driven at once.
                  txsh_r            <= tx_data;
                  txn_r             <= 4'h8;
                  txen_r            <= 1'b1;
                  txmid_r           <= 1'b1;
                  last_r            <= 1'b0;
                  tx_take           <= 1'b1;
                  serial_io_line_oe <= 1'b1;
                  serial_io_line_o  <= first_half(tx_data[7]);
                end else begin
                  state_r <= ST_RX;
                  nbit_r  <= 4'h0;
                end
              end
            end else if (txmid_r && cnt_r == te_r) begin
              // Middle of the slave bit: it becomes the new time reference.
              serial_io_line_o <= txsh_r[7];
              txsh_r           <= {txsh_r[6:0], 1'b0};
              txn_r            <= txn_r - 4'h1;
              txmid_r          <= 1'b0;
              cnt_r            <= 17'h0;
            end
          end
          default: begin
            state_r           <= ST_IDLE;
            serial_io_line_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Write cycle timer
  // --------------------------------------------------------------------------
  swb_wrtimer #(
    .SHORT_CYC (TWC_CYC),
    .LONG_CYC  (TWC_LONG_CYC)
  ) u_wrtimer (
    .clk      (ref_clk),
    .resetn   (resetn),
    .start    (wr_go_r),
    .long_sel (wr_long),
    .busy_r   (wr_busy)
  );

endmodule // swb_link

/* File: pkg/swb_map.vh */
// Constants for the single-wire bus framing block: timing counts and frame layout.
`ifndef SWB_MAP_VH
`define SWB_MAP_VH

// ----------------------------------------------------------------------------
// Clock and time bases
// ----------------------------------------------------------------------------
`define SWB_CLK_KHZ        125000
`define SWB_STBY_US        600
`define SWB_STBY_CYC       ((`SWB_STBY_US * `SWB_CLK_KHZ) / 1000)
`define SWB_TE_MIN_US      10
`define SWB_TE_MIN_CYC     ((`SWB_TE_MIN_US * `SWB_CLK_KHZ) / 1000)
`define SWB_TE_MAX_US      100
`define SWB_TE_MAX_CYC     ((`SWB_TE_MAX_US * `SWB_CLK_KHZ) / 1000)
`define SWB_TWC_MS         5
`define SWB_TWC_CYC        (`SWB_TWC_MS * `SWB_CLK_KHZ)
`define SWB_TWC_LONG_MS    10
`define SWB_TWC_LONG_CYC   (`SWB_TWC_LONG_MS * `SWB_CLK_KHZ)

// ----------------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------------
`define SWB_HDR_EDGES      4'h8
`define SWB_HDR_MEAS_EDGE  4'h4
`define SWB_ACK_BIT        4'h8
`define SWB_LAST_BIT       4'h7
`define SWB_INSTR_BYTE     2'h1

`endif

/* File: rtl/swb_sync.v */
// Two-stage synchroniser for the bus line with level and edge outputs.
`timescale 1ns/1ns
module swb_sync (
  input  wire clk,    // Sampling clock
  input  wire resetn, // Synchronous reset, active low
  input  wire din,    // Asynchronous line level
  output wire lvl,    // Synchronised level
  output wire rise,   // One-cycle pulse on a rising edge
  output wire fall    // One-cycle pulse on a falling edge
);

  reg s1_r;
  reg s2_r;
  reg s3_r;

  // The idle line is pulled high, so every stage resets to one.
  always @(posedge clk) begin
    if (!resetn) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign lvl  = s2_r;
  assign rise = s2_r & ~s3_r;
  assign fall = ~s2_r & s3_r;

endmodule // swb_sync

/* File: rtl/swb_wrtimer.v */
// Self-timed write cycle timer with a short and a long duration.
`timescale 1ns/1ns
module swb_wrtimer #(
  parameter [20:0] SHORT_CYC = 21'h1,
  parameter [20:0] LONG_CYC  = 21'h2
) (
  input  wire clk,      // Clock
  input  wire resetn,   // Synchronous reset, active low
  input  wire start,    // One-cycle pulse that starts a write cycle
  input  wire long_sel, // Selects the long duration
  output reg  busy_r    // High while the write cycle runs
);

  reg [20:0] cnt_r;

  // A start while busy is ignored; the running cycle is never stretched.
  always @(posedge clk) begin
    if (!resetn) begin
      cnt_r  <= 21'h0;
      busy_r <= 1'b0;
    end else if (start && !busy_r) begin
      cnt_r  <= (long_sel ? LONG_CYC : SHORT_CYC) - 21'h1;
      busy_r <= 1'b1;
    end else if (busy_r) begin
      if (cnt_r == 21'h0) begin
        busy_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r - 21'h1;
      end
    end
  end

endmodule // swb_wrtimer

/* File: sim/swb_master_model.sv */
// Bus master model for the single-wire link, timed by its own 80 ns tick.
`timescale 1ns/1ns
module swb_master_model (
  input  wire slv_o,  // Slave output level
  input  wire slv_oe, // Slave drive enable
  output wire line    // Resolved line level
);
  localparam HB = 64;
  reg lclk = 1'b0;
  reg m_o  = 1'b1;
  reg m_oe = 1'b1;
  initial begin
    #3;
    forever #40 lclk = ~lclk;
  end
  // The line has a pull-up, so a released line reads high.
  assign line = slv_oe ? slv_o : (m_oe ? m_o : 1'b1);
  // ----------------------------------------
  // Master bit, byte and framing tasks
  // ----------------------------------------
  task half(input v);
    begin
      m_o = v;
      repeat (HB) @(posedge lclk);
    end
  endtask
  task mbit(input b);
    begin
      m_oe = 1'b1;
      half(~b);
      half(b);
    end
  endtask
  task mbyte(input [7:0] d);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) mbit(d[i]);
    end
  endtask
  task stby;
    begin
      m_oe = 1'b1;
      half(1'b0);
      m_o = 1'b1;
      repeat (450) @(posedge lclk);
    end
  endtask
  task gap;
    begin
      m_oe = 1'b1;
      half(1'b1);
      half(1'b1);
    end
  endtask
  task header;
    begin
      m_oe = 1'b1;
      half(1'b0);
      half(1'b0);
      mbyte(8'h55);
    end
  endtask
  // Samples the slave's bit at one quarter and three quarters of its period.
  task sbit(output [1:0] r);
    begin
      m_oe = 1'b0;
      repeat (HB / 2) @(posedge lclk);
      r[1] = line;
      repeat (HB) @(posedge lclk);
      r[0] = line;
      repeat (HB / 2) @(posedge lclk);
    end
  endtask
  task sbyte(output [7:0] d);
    reg [1:0] r;
    integer   i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        sbit(r);
        d[i] = r[0];
      end
    end
  endtask
endmodule // swb_master_model

/* File: sim/swb_link_sva.sv */
// Concurrent checks on the ports of the slave framing block.
`timescale 1ns/1ns
module swb_link_sva #(
  parameter [16:0] STBY_CYC     = 17'h00C80,
  parameter [20:0] TWC_CYC      = 21'h00012C,
  parameter [20:0] TWC_LONG_CYC = 21'h000258,
  parameter int    TE_CYC       = 1280
) (
  input wire       ref_clk,           // Clock
  input wire       resetn,            // Reset, active low
  input wire       serial_io_line_i,  // Line level
  input wire       serial_io_line_oe, // Slave drive enable
  input wire [7:0] rx_data,           // Received byte
  input wire       rx_valid,          // Byte pulse
  input wire       mak_bit,           // Master ack value
  input wire       mak_valid,         // Master ack pulse
  input wire [7:0] instr,             // Instruction register
  input wire       wr_arm,            // Write pending
  input wire       wr_long,           // Long write
  input wire       wr_busy,           // Write running
  input wire       standby            // Standby state
);
  localparam int MAK_LO = TE_CYC * 3 / 4;
  localparam int MAK_HI = TE_CYC * 5 / 4 + 16;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  reg [20:0] busy_cnt_r;
  reg        long_r;
  reg        line_d_r;
  reg        rose_r;
  reg [16:0] hi_cnt_r;
  reg [15:0] since_rx_r;
  always @(posedge ref_clk) begin
    if (!resetn) begin
      busy_cnt_r <= 21'h000000;
      long_r     <= 1'b0;
      line_d_r   <= 1'b1;
      rose_r     <= 1'b0;
      hi_cnt_r   <= 17'h00000;
      since_rx_r <= 16'hFFFF;
    end else begin
      busy_cnt_r <= wr_busy ? busy_cnt_r + 21'h000001 : 21'h000000;
      if (wr_busy && busy_cnt_r == 21'h000000)
        long_r <= wr_long;
      line_d_r <= serial_io_line_i;
      if (serial_io_line_i && !line_d_r)
        rose_r <= 1'b1;
      // A high run counts only while nobody but the pull-up or master holds it high.
      if (!serial_io_line_i || serial_io_line_oe || !rose_r)
        hi_cnt_r <= 17'h00000;
      else if (hi_cnt_r != 17'h1FFFF)
        hi_cnt_r <= hi_cnt_r + 17'h00001;
      if (rx_valid)
        since_rx_r <= 16'h0000;
      else if (since_rx_r != 16'hFFFF)
        since_rx_r <= since_rx_r + 16'h0001;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_master_not_acknowledge;
    mak_valid && !mak_bit && wr_arm;
  endsequence
  sequence s_wake;
    standby && $fell(serial_io_line_i);
  endsequence
  oe_standby_a: assert property (standby |-> !serial_io_line_oe)
    else $error("slave drives the line in standby");
  ack_quiet_a: assert property (mak_valid |=> !serial_io_line_oe [*8])
    else $error("slave drives during the master ack bit");
  wr_start_a: assert property (s_master_not_acknowledge |-> ##[1:4] wr_busy)
    else $error("write cycle did not start after master not-ack");
  wr_len_a: assert property ($fell(wr_busy) |->
    busy_cnt_r == (long_r ? TWC_LONG_CYC : TWC_CYC))
    else $error("write cycle length wrong");
  instr_load_a: assert property ($changed(instr) |-> rx_valid && instr == rx_data)
    else $error("instruction register changed without a received byte");
  rx_gap_a: assert property (rx_valid |=> !rx_valid [*8])
    else $error("byte pulses too close");
  mak_time_a: assert property (mak_valid && since_rx_r < 16'h0FA0 |->
    since_rx_r >= MAK_LO && since_rx_r <= MAK_HI)
    else $error("master ack not one bit after the byte");
  stby_enter_a: assert property (hi_cnt_r == STBY_CYC + 17'h0000A |-> standby)
    else $error("standby pulse not honoured");
  stby_exit_a: assert property (s_wake |-> ##[1:8] !standby)
    else $error("standby not left on falling edge");
endmodule // swb_link_sva

bind swb_link swb_link_sva #(.STBY_CYC(STBY_CYC), .TWC_CYC(TWC_CYC),
  .TWC_LONG_CYC(TWC_LONG_CYC)) u_sva (.ref_clk(ref_clk), .resetn(resetn),
  .serial_io_line_i(serial_io_line_i), .serial_io_line_oe(serial_io_line_oe),
  .rx_data(rx_data), .rx_valid(rx_valid), .mak_bit(mak_bit), .mak_valid(mak_valid),
  .instr(instr), .wr_arm(wr_arm), .wr_long(wr_long), .wr_busy(wr_busy),
  .standby(standby));

/* File: sim/testbench.sv */
// Self-checking bench for the slave framing block against a bus master model.
`timescale 1ns/1ns
module testbench;
  reg        ref_clk = 1'b0;
  reg        resetn  = 1'b0;
  reg        ack_ok, tx_valid, wr_arm, wr_long;
  reg  [7:0] tx_data;
  reg  [7:0] rx_last, rx_prev;
  wire       line, so, soe, rx_valid, wr_busy, standby;
  wire [7:0] rx_data, instr;
  wire       mak_bit, mak_valid, tx_take, sync_lost;
  integer    errors = 0, samples_checked = 0, cyc = 0, busy_cnt = 0, busy_len = 0;
  integer    mak_cnt = 0, take_cnt = 0, lost_cnt = 0;
  always #4 ref_clk = ~ref_clk;
  swb_link #(.STBY_CYC(17'h00C80), .TWC_CYC(21'h00012C), .TWC_LONG_CYC(21'h000258)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .serial_io_line_i(line),
    .serial_io_line_o(so), .serial_io_line_oe(soe), .rx_data(rx_data),
    .rx_valid(rx_valid), .mak_bit(mak_bit), .mak_valid(mak_valid), .ack_ok(ack_ok),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_take(tx_take), .instr(instr),
    .wr_arm(wr_arm), .wr_long(wr_long), .wr_busy(wr_busy), .standby(standby),
    .sync_lost(sync_lost));
  swb_master_model m (.slv_o(so), .slv_oe(soe), .line(line));
  // ----------------------------------------
  // Monitors and timeout
  // ----------------------------------------
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (rx_valid === 1'b1) begin
      rx_prev <= rx_last;
      rx_last <= rx_data;
    end
    if (wr_busy === 1'b1) busy_cnt <= busy_cnt + 1;
    else if (busy_cnt != 0) begin
      busy_len <= busy_cnt;
      busy_cnt <= 0;
    end
    if (mak_valid === 1'b1) mak_cnt <= mak_cnt + 1;
    if (tx_take === 1'b1) take_cnt <= take_cnt + 1;
    if (resetn && sync_lost !== 1'b0) lost_cnt <= lost_cnt + 1;
    if (cyc == 106000) begin
      errors = errors + 1;
      $display("[ERR] %0t run did not finish", $time);
      finish_test;
    end
  end
  task chk(input [15:0] got, input [15:0] exp, input [8*8:1] what);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("[ERR] %0t %0s got %h expected %h", $time, what, got, exp);
      end
    end
  endtask
  task finish_test;
    begin
      $display("Checks made %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_standby;
    begin
      m.stby;
      chk(16'(standby), 16'h0001, "standby");
      chk(16'(soe), 16'h0000, "oe");
    end
  endtask
  task t_write;
    reg [1:0] a;
    begin
      @(negedge ref_clk);
      ack_ok = 1'b1;
      wr_arm = 1'b1;
      wr_long = 1'b0;
      m.header;
      chk(16'(standby), 16'h0000, "wake");
      m.mbit(1'b1);
      m.sbit(a);
      chk(16'(a), 16'h0003, "hdr ack");
      m.mbyte(8'h5A);
      m.mbit(1'b1);
      m.sbit(a);
      chk(16'(a), 16'h0001, "addr ack");
      m.mbyte(8'hC3);
      m.mbit(1'b0);
      m.sbit(a);
      chk(16'(a), 16'h0001, "end ack");
      chk(16'(rx_prev), 16'h005A, "addr");
      chk(16'(instr), 16'h00C3, "instr");
      chk(busy_len[15:0], 16'h012C, "short wr");
      // Standby follows the end of the slave bit as the slave sees it, a few cycles late.
      repeat (16) @(negedge ref_clk);
      chk(16'(standby), 16'h0001, "standby");
    end
  endtask
  task t_read;
    reg [1:0] a;
    reg [7:0] d;
    begin
      @(negedge ref_clk);
      wr_arm = 1'b0;
      wr_long = 1'b1;
      tx_data = 8'h96;
      m.gap;
      m.header;
      m.mbit(1'b1);
      m.sbit(a);
      chk(16'(a), 16'h0003, "hdr ack");
      m.mbyte(8'h5A);
      @(negedge ref_clk);
      ack_ok = 1'b0;
      m.mbit(1'b1);
      m.sbit(a);
      chk(16'(a), 16'h0003, "addr nak");
      @(negedge ref_clk);
      ack_ok = 1'b1;
      m.mbyte(8'h3C);
      m.mbit(1'b1);
      @(negedge ref_clk);
      tx_valid = 1'b1;
      m.sbit(a);
      chk(16'(a), 16'h0001, "cmd ack");
      chk(16'(rx_last), 16'h003C, "instr");
      m.sbyte(d);
      chk(16'(d), 16'h0096, "tx byte");
      @(negedge ref_clk);
      tx_valid = 1'b0;
      wr_arm = 1'b1;
      m.mbit(1'b0);
      m.sbit(a);
      chk(16'(a), 16'h0001, "end ack");
      chk(busy_len[15:0], 16'h0258, "long wr");
      chk(16'(mak_bit), 16'h0000, "mak bit");
      chk(16'(mak_cnt), 16'h0007, "mak cnt");
      chk(16'(take_cnt), 16'h0001, "tx take");
      chk(16'(lost_cnt), 16'h0000, "no slip");
    end
  endtask
  initial begin
    ack_ok = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    wr_arm = 1'b0;
    wr_long = 1'b0;
    repeat (4) @(negedge ref_clk);
    resetn = 1'b1;
    t_standby;
    t_write;
    t_read;
    finish_test;
  end
endmodule // testbench
